//--- logic/sct_defs.vh
// constants for the spi control channel tunnel
`ifndef SCT_DEFS_VH
`define SCT_DEFS_VH
`define SCT_REG_MODE 8'h43
`define SCT_REG_BC 8'h23
`define SCT_REG_STATUS 8'h44
`define SCT_MODE_RST 8'h00
`define SCT_BC_RST 8'h00
`define SCT_MODE_MSB 2
`define SCT_MODE_FWD 3'h6
`define SCT_MODE_REV 3'h7
`define SCT_BC_DIV2_BIT 6
`define SCT_BC_FAST_BIT 4
`define SCT_ST_ON_BIT 0
`define SCT_ST_FWD_BIT 1
`define SCT_ST_REV_BIT 2
`define SCT_ST_OVF_BIT 3
`define SCT_ST_PEND_BIT 4
`define SCT_I2C_ADDR 7'h2c
`define SCT_CLK_NS 5
`define SCT_FRAME_20M_NS 1875
`define SCT_FRAME_20M_CYC (`SCT_FRAME_20M_NS / `SCT_CLK_NS)
`endif

//--- logic/sct_i2c_slave.v
// i2c register port slave for the tunnel configuration
`timescale 1ns/10ps
`default_nettype none
`include "sct_defs.vh"
module sct_i2c_slave #(
  parameter [6:0] DEV_ADDR = `SCT_I2C_ADDR
)(
  // clock and reset
  input wire clk_i,
  input wire resetn_i,
  // pins
  input wire scl_i,
  input wire sda_i,
  output reg sda_oe_n_o,
  // register side
  output reg reg_wr_o,
  output reg [7:0] reg_addr_o,
  output reg [7:0] reg_wdata_o,
  input wire [7:0] reg_rdata_i
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACKA = 3'h2;
  localparam [2:0] ST_RX = 3'h3;
  localparam [2:0] ST_ACKR = 3'h4;
  localparam [2:0] ST_RD = 3'h5;
  localparam [2:0] ST_RLOAD = 3'h6;
  reg scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  reg [2:0] state;
  reg [3:0] cnt;
  reg [7:0] sh;
  reg rw, ptr_ok, wrote;
  wire scl_rise = scl_s & ~scl_p;
  wire scl_fall = ~scl_s & scl_p;
  wire start = scl_s & scl_p & sda_p & ~sda_s;
  wire stop = scl_s & scl_p & ~sda_p & sda_s;
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
      state <= ST_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      rw <= 1'b0;
      ptr_ok <= 1'b0;
      wrote <= 1'b0;
      sda_oe_n_o <= 1'b1;
      reg_wr_o <= 1'b0;
      reg_addr_o <= 8'h00;
      reg_wdata_o <= 8'h00;
    end
    else
    begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_p <= sda_s;
      reg_wr_o <= 1'b0;
      if (start)
      begin
        state <= ST_ADDR;
        cnt <= 4'h0;
        ptr_ok <= 1'b0;
        sda_oe_n_o <= 1'b1;
      end
      else if (stop)
      begin
        state <= ST_IDLE;
        sda_oe_n_o <= 1'b1;
      end
      else
      begin
        case (state)
          ST_ADDR, ST_RX:
          begin
            if (scl_rise)
            begin
              sh <= {sh[6:0], sda_s};
              cnt <= cnt + 4'h1;
            end
            else if (scl_fall && cnt == 4'h8)
            begin
              if (state == ST_ADDR)
              begin
                rw <= sh[0];
                if (sh[7:1] == DEV_ADDR)
                begin
                  sda_oe_n_o <= 1'b0;
                  state <= ST_ACKA;
                end
                else
                  state <= ST_IDLE;
              end
              else
              begin
                sda_oe_n_o <= 1'b0;
                state <= ST_ACKR;
                wrote <= ptr_ok;
                if (!ptr_ok)
                begin
                  reg_addr_o <= sh;
                  ptr_ok <= 1'b1;
                end
                else
                begin
                  reg_wdata_o <= sh;
                  reg_wr_o <= 1'b1;
                end
              end
            end
          end
          ST_ACKA:
          begin
            if (scl_fall)
            begin
              cnt <= 4'h0;
              if (rw)
              begin
                sh <= reg_rdata_i;
                sda_oe_n_o <= reg_rdata_i[7];
                state <= ST_RD;
              end
              else
              begin
                sda_oe_n_o <= 1'b1;
                state <= ST_RX;
              end
            end
          end
          ST_ACKR:
          begin
            if (scl_fall)
            begin
              sda_oe_n_o <= 1'b1;
              cnt <= 4'h0;
              state <= ST_RX;
              if (wrote)
                reg_addr_o <= reg_addr_o + 8'h01;
            end
          end
          ST_RD:
          begin
            if (scl_rise)
            begin
              if (cnt == 4'h8)
              begin
                if (sda_s)
                  state <= ST_IDLE;
                else
                begin
                  reg_addr_o <= reg_addr_o + 8'h01;
                  state <= ST_RLOAD;
                end
              end
              else
                cnt <= cnt + 4'h1;
            end
            else if (scl_fall)
            begin
              if (cnt == 4'h8)
                sda_oe_n_o <= 1'b1;
              else if (cnt != 4'h0)
              begin
                sh <= {sh[6:0], 1'b1};
                sda_oe_n_o <= sh[6];
              end
            end
          end
          ST_RLOAD:
          begin
            if (scl_fall)
            begin
              sh <= reg_rdata_i;
              sda_oe_n_o <= reg_rdata_i[7];
              cnt <= 4'h0;
              state <= ST_RD;
            end
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // sct_i2c_slave
`default_nettype wire

//--- logic/sct_tunnel.v
// spi control channel tunnel of the deserializer
`timescale 1ns/10ps
`default_nettype none
`include "sct_defs.vh"
// Summary of operation
// R01: tunnel only with two-lane link running
// R02: forward mode regenerates master's spi locally
// R03: reverse mode sends local master upstream
// R04: mode field 0x43[2:0], 110 fwd, 111 rev
// R05: tunnel never touches configuration registers
// R06: read clock slower than round trip
// R07: write-only transfers may ignore returned data
// R08: serializer oversamples spi with pixel clock
// R09: regenerate with pixel clock, hold mosi
// R10: regenerated clock one pixel after data
// R11: select and clock synchronised before use
// R12: active clock edge buffers mosi bit
// R13: each frame carries select, one sample
// R14: select high one frame between transfers
// R15: reverse reads wait for round trip
// R16: frame rate from divider, 0x23 bits
// R17: idle or unlocked: select high, clock low
module sct_tunnel #(
  parameter BUF_DEPTH = 16,
  parameter PTR_W = 4,
  parameter [7:0] MODE_RST = `SCT_MODE_RST,
  parameter [7:0] BC_RST = `SCT_BC_RST
)(
  // clock and reset
  input wire CLK_I,
  input wire RESETN_I,
  // i2c configuration pins
  input wire SCL_I,
  input wire SDA_I,
  output reg SDA_O,
  output wire SDA_OE_N_O,
  // link status
  input wire LINK_LOCK_I,
  input wire TWO_LANE_I,
  // forward frame samples, one strobe per pixel
  input wire FWD_STROBE_I,
  input wire FWD_SCLK_I,
  input wire FWD_MOSI_I,
  input wire FWD_SS_N_I,
  input wire FWD_MISO_I,
  // regenerated spi to local slaves
  output reg REGENERATED_SPI_CLOCK_O,
  output reg REGEN_MOSI_O,
  output reg REGEN_SS_N_O,
  input wire SLAVE_MISO_I,
  // local spi master pins
  input wire MASTER_SCLK_I,
  input wire MASTER_MOSI_I,
  input wire MASTER_SS_N_I,
  output reg MASTER_MISO_O,
  // back channel frame contents
  output reg BC_FRAME_O,
  output reg BC_SS_N_O,
  output reg BC_CLK_O,
  output reg BC_MOSI_O,
  output reg BC_MISO_O
);
  reg [7:0] control_channel_mode;
  reg [7:0] bc_cfg;
  reg [7:0] rdata;
  reg ovf;
  wire reg_wr;
  wire [7:0] reg_addr;
  wire [7:0] reg_wdata;
  wire [2:0] tunnel_mode_select = control_channel_mode[`SCT_MODE_MSB:0];
  wire back_channel_fast_rate = bc_cfg[`SCT_BC_FAST_BIT];
  wire link_ok = LINK_LOCK_I & TWO_LANE_I; // R01
  wire fwd_on = link_ok & (tunnel_mode_select == `SCT_MODE_FWD); // R02 R04
  wire rev_on = link_ok & (tunnel_mode_select == `SCT_MODE_REV); // R03 R04

  // register port; spi traffic has no path into these registers
  sct_i2c_slave #(
    .DEV_ADDR(`SCT_I2C_ADDR)
  ) u_i2c (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .sda_oe_n_o(SDA_OE_N_O),
    .reg_wr_o(reg_wr),
    .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata),
    .reg_rdata_i(rdata)
  );

  always @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      control_channel_mode <= MODE_RST;
      bc_cfg <= BC_RST;
      SDA_O <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `SCT_REG_MODE)
        control_channel_mode <= reg_wdata; // R04 R05
      else if (reg_addr == `SCT_REG_BC)
        bc_cfg <= reg_wdata;
    end
  end

  reg [PTR_W:0] cnt;
  always @*
  begin
    rdata = 8'h00;
    if (reg_addr == `SCT_REG_MODE)
      rdata = control_channel_mode;
    else if (reg_addr == `SCT_REG_BC)
      rdata = bc_cfg;
    else if (reg_addr == `SCT_REG_STATUS)
    begin
      rdata[`SCT_ST_ON_BIT] = fwd_on | rev_on;
      rdata[`SCT_ST_FWD_BIT] = fwd_on;
      rdata[`SCT_ST_REV_BIT] = rev_on;
      rdata[`SCT_ST_OVF_BIT] = ovf;
      rdata[`SCT_ST_PEND_BIT] = (cnt != {(PTR_W+1){1'b0}});
    end
  end

  // forward regeneration on pixel strobes
  reg fwd_sclk_d;
  always @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      fwd_sclk_d <= 1'b0;
      REGENERATED_SPI_CLOCK_O <= 1'b0;
      REGEN_MOSI_O <= 1'b0;
      REGEN_SS_N_O <= 1'b1;
      MASTER_MISO_O <= 1'b0;
    end
    else if (!fwd_on)
    begin
      fwd_sclk_d <= 1'b0;
      REGENERATED_SPI_CLOCK_O <= 1'b0; // R17
      REGEN_SS_N_O <= 1'b1; // R17
      if (rev_on && FWD_STROBE_I)
        MASTER_MISO_O <= FWD_MISO_I;
    end
    else if (FWD_STROBE_I)
    begin
      fwd_sclk_d <= FWD_SCLK_I;
      REGENERATED_SPI_CLOCK_O <= fwd_sclk_d; // R10 R09
      REGEN_SS_N_O <= FWD_SS_N_I;
      if (!REGENERATED_SPI_CLOCK_O && !fwd_sclk_d)
        REGEN_MOSI_O <= FWD_MOSI_I; // R09
    end
  end

  // master and slave pins pass two flops first
  reg ss_m, ss_s, sck_m, sck_s, sck_p, mo_m, mo_s, mi_m, mi_s;
  always @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      ss_m <= 1'b1;
      ss_s <= 1'b1;
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_p <= 1'b0;
      mo_m <= 1'b0;
      mo_s <= 1'b0;
      mi_m <= 1'b0;
      mi_s <= 1'b0;
    end
    else
    begin
      ss_m <= MASTER_SS_N_I; // R11
      ss_s <= ss_m;
      sck_m <= MASTER_SCLK_I; // R11
      sck_s <= sck_m;
      sck_p <= sck_s;
      mo_m <= MASTER_MOSI_I;
      mo_s <= mo_m;
      mi_m <= SLAVE_MISO_I;
      mi_s <= mi_m;
    end
  end
  wire sck_edge = rev_on & ~ss_s & sck_s & ~sck_p;

  // frame divider: 20, 10 or 5 Mbps frame period
  localparam [31:0] FRAME_BASE_W = `SCT_FRAME_20M_CYC;
  localparam [10:0] FRAME_BASE = FRAME_BASE_W[10:0];
  reg [10:0] fcnt;
  reg [10:0] frame_len;
  always @*
  begin
    if (back_channel_fast_rate)
      frame_len = FRAME_BASE; // R16
    else if (bc_cfg[`SCT_BC_DIV2_BIT])
      frame_len = {FRAME_BASE[9:0], 1'b0}; // R16
    else
      frame_len = {FRAME_BASE[8:0], 2'b00}; // R16
  end
  wire frame_tick = (fcnt == 11'h000);
  always @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      fcnt <= 11'h000;
    else if (frame_tick || fcnt >= frame_len)
      fcnt <= frame_len - 11'h001;
    else
      fcnt <= fcnt - 11'h001;
  end

  // mosi sample buffer, drained one bit per frame
  reg [BUF_DEPTH-1:0] buf_bits;
  reg [PTR_W-1:0] wr_ptr, rd_ptr;
  wire pop = frame_tick & rev_on & (cnt != {(PTR_W+1){1'b0}});
  wire full = (cnt == BUF_DEPTH[PTR_W:0]);
  wire push = sck_edge & ~full;
  always @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      buf_bits <= {BUF_DEPTH{1'b0}};
      wr_ptr <= {PTR_W{1'b0}};
      rd_ptr <= {PTR_W{1'b0}};
      cnt <= {(PTR_W+1){1'b0}};
      ovf <= 1'b0;
    end
    else if (!rev_on)
    begin
      wr_ptr <= {PTR_W{1'b0}};
      rd_ptr <= {PTR_W{1'b0}};
      cnt <= {(PTR_W+1){1'b0}};
      ovf <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        buf_bits[wr_ptr] <= mo_s; // R12
        wr_ptr <= (wr_ptr == BUF_DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : wr_ptr + 1'b1;
      end
      if (sck_edge && full)
        ovf <= 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == BUF_DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : rd_ptr + 1'b1;
      if (push && !pop)
        cnt <= cnt + 1'b1;
      else if (pop && !push)
        cnt <= cnt - 1'b1;
    end
  end

  // back channel frame assembly
  always @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      BC_FRAME_O <= 1'b0;
      BC_SS_N_O <= 1'b1;
      BC_CLK_O <= 1'b0;
      BC_MOSI_O <= 1'b0;
      BC_MISO_O <= 1'b0;
    end
    else
    begin
      BC_FRAME_O <= frame_tick & (fwd_on | rev_on);
      if (frame_tick)
      begin
        BC_SS_N_O <= rev_on ? ss_s : 1'b1; // R13
        BC_CLK_O <= pop; // R13
        BC_MOSI_O <= pop ? buf_bits[rd_ptr] : 1'b0; // R13
        BC_MISO_O <= fwd_on ? mi_s : 1'b0;
      end
    end
  end
endmodule // sct_tunnel
`default_nettype wire

//--- verif/sct_tunnel_checker.sv
// port assertions for the spi control channel tunnel
`timescale 1ns/10ps
`default_nettype none
`include "sct_defs.vh"
module sct_tunnel_checker (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // link status and forward samples
  input wire logic LINK_LOCK_I,
  input wire logic TWO_LANE_I,
  input wire logic FWD_STROBE_I,
  input wire logic FWD_SS_N_I,
  // regenerated spi and back channel
  input wire logic REGENERATED_SPI_CLOCK_O,
  input wire logic REGEN_MOSI_O,
  input wire logic REGEN_SS_N_O,
  input wire logic BC_FRAME_O,
  input wire logic BC_CLK_O,
  input wire logic BC_MOSI_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESETN_I);
  localparam int FRAME_MIN = `SCT_FRAME_20M_CYC;
  logic [10:0] gap;
  // cycles since the last frame, saturating
  always @(posedge CLK_I or negedge RESETN_I)
    if (!RESETN_I)
      gap <= 11'h7ff;
    else if (BC_FRAME_O)
      gap <= 11'h001;
    else if (gap != 11'h7ff)
      gap <= gap + 11'h001;
  AST_IDLE_OUT: assert property (!LINK_LOCK_I |=> REGEN_SS_N_O && !REGENERATED_SPI_CLOCK_O)
    else $error("regenerated spi not idle");
  AST_ONE_LANE: assert property (!TWO_LANE_I [*3] |-> !BC_FRAME_O)
    else $error("frame on single lane");
  AST_SS_FALL: assert property ($fell(REGEN_SS_N_O) |-> $past(FWD_STROBE_I) && !$past(FWD_SS_N_I))
    else $error("select fell without sample");
  AST_MOSI_HOLD: assert property (REGENERATED_SPI_CLOCK_O && $past(REGENERATED_SPI_CLOCK_O) |-> $stable(REGEN_MOSI_O))
    else $error("mosi moved while clock high");
  AST_CLK_STROBE: assert property ($rose(REGENERATED_SPI_CLOCK_O) |-> $past(FWD_STROBE_I))
    else $error("clock rose off strobe");
  AST_MOSI_SETUP: assert property ($rose(REGENERATED_SPI_CLOCK_O) |-> REGEN_MOSI_O == $past(REGEN_MOSI_O, 3))
    else $error("no setup before clock");
  AST_FRAME_GAP: assert property (BC_FRAME_O |-> gap >= FRAME_MIN)
    else $error("frames too close");
  AST_FRAME_HOLD: assert property (!BC_FRAME_O |-> $stable(BC_CLK_O) && $stable(BC_MOSI_O))
    else $error("sample changed between frames");
  COV_SAMPLE: cover property (BC_FRAME_O && BC_CLK_O);
  COV_CLK: cover property ($rose(REGENERATED_SPI_CLOCK_O));
  COV_SS: cover property ($fell(REGEN_SS_N_O));
endmodule // sct_tunnel_checker
bind sct_tunnel sct_tunnel_checker u_sct_tunnel_checker (.CLK_I, .RESETN_I, .LINK_LOCK_I,
  .TWO_LANE_I, .FWD_STROBE_I, .FWD_SS_N_I, .REGENERATED_SPI_CLOCK_O, .REGEN_MOSI_O,
  .REGEN_SS_N_O, .BC_FRAME_O, .BC_CLK_O, .BC_MOSI_O);
`default_nettype wire

//--- verif/sct_spi_partner.sv
// serializer side: spi master oversampled into pixel strobes
`timescale 1ns/10ps
`default_nettype none
module sct_spi_partner (
  // clock and control
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] data_i,
  output logic busy_o,
  // forward frame samples
  output logic strobe_o,
  output logic sclk_o,
  output logic mosi_o,
  output logic ss_n_o,
  output logic miso_o
);
  logic [1:0] div = 2'h0;
  logic [5:0] p = 6'h00;
  logic run = 1'b0;
  logic [7:0] d = 8'h00;
  wire [5:0] q = p - 6'h04;
  assign busy_o = run;
  assign strobe_o = div == 2'h3;
  assign ss_n_o = !run;
  // write only: clock half period two strobes, returned data ignored
  assign sclk_o = run && p >= 6'h04 && p < 6'h24 && q[1];
  assign mosi_o = d[3'h7 - q[4:2]];
  assign miso_o = p[0];
  always @(posedge clk_i)
  begin
    div <= div + 2'h1;
    if (strobe_o)
    begin
      p <= run ? p + 6'h01 : 6'h00;
      if (p == 6'h27)
        run <= 1'b0;
      if (!run && go_i)
      begin
        run <= 1'b1;
        d <= data_i;
      end
    end
  end
endmodule // sct_spi_partner
`default_nettype wire

//--- verif/sct_tunnel_test.sv
// self-checking bench for the spi control channel tunnel
`timescale 1ns/10ps
`default_nettype none
`include "sct_defs.vh"
module sct_tunnel_test;
  localparam int F = `SCT_FRAME_20M_CYC;
  logic clk = 1'b0, resetn = 1'b0, scl = 1'b1, sda_m = 1'b1, lock = 1'b1, two = 1'b1;
  logic ms_sclk = 1'b0, ms_mosi = 1'b0, ms_ss_n = 1'b1, go = 1'b0, rev = 1'b0, prev_clk = 1'b0;
  logic [7:0] data = 8'h00, rv;
  logic s_d = 1'b0, m_d = 1'b0, rx_bit = 1'b1;
  logic [7:0] rate [3] = '{8'h00, 8'h40, 8'h50};
  int per [3] = '{4 * F, 2 * F, F};
  wire strobe, f_sclk, f_mosi, f_ss_n, f_miso, busy, sda_oe_n, rclk, rmosi, rss_n;
  wire bc_frame, bc_ss_n, bc_clk, bc_mosi, bc_miso, mmiso;
  logic q[$];
  int n_fail = 0, n_tests = 0, cyc = 0, n_frames = 0, t0, k;
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) cyc++;
  sct_spi_partner u_sct_spi_partner (.clk_i(clk), .go_i(go), .data_i(data), .busy_o(busy),
    .strobe_o(strobe), .sclk_o(f_sclk), .mosi_o(f_mosi), .ss_n_o(f_ss_n), .miso_o(f_miso));
  sct_tunnel u_sct_tunnel (.CLK_I(clk), .RESETN_I(resetn), .SCL_I(scl), .SDA_I(sda_m & sda_oe_n),
    .SDA_O(), .SDA_OE_N_O(sda_oe_n), .LINK_LOCK_I(lock), .TWO_LANE_I(two), .FWD_STROBE_I(strobe),
    .FWD_SCLK_I(f_sclk), .FWD_MOSI_I(f_mosi), .FWD_SS_N_I(f_ss_n), .FWD_MISO_I(f_miso),
    .REGENERATED_SPI_CLOCK_O(rclk), .REGEN_MOSI_O(rmosi), .REGEN_SS_N_O(rss_n),
    .SLAVE_MISO_I(rmosi), .MASTER_SCLK_I(ms_sclk), .MASTER_MOSI_I(ms_mosi),
    .MASTER_SS_N_I(ms_ss_n), .MASTER_MISO_O(mmiso), .BC_FRAME_O(bc_frame), .BC_SS_N_O(bc_ss_n),
    .BC_CLK_O(bc_clk), .BC_MOSI_O(bc_mosi), .BC_MISO_O(bc_miso));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic i2c_bit(input logic b, input logic ack);
    sda_m = b;
    tick(10);
    scl = 1'b1;
    tick(10);
    rx_bit = sda_m & sda_oe_n;
    if (ack)
      check(sda_oe_n, 1'b0);
    tick(10);
    scl = 1'b0;
    tick(10);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [23:0] s;
    s = {`SCT_I2C_ADDR, 1'b0, a, d};
    sda_m = 1'b0;
    tick(10);
    scl = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      i2c_bit(s[i], 1'b0);
      if (i % 8 == 0)
        i2c_bit(1'b1, 1'b1);
    end
    sda_m = 1'b0;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_m = 1'b1;
    tick(10);
  endtask
  // pointer write, repeated start, one byte read, then no-ack
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic [15:0] s;
    s = {`SCT_I2C_ADDR, 1'b0, a};
    v = 8'h00;
    sda_m = 1'b0;
    tick(10);
    scl = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      i2c_bit(s[i], 1'b0);
      if (i % 8 == 0)
        i2c_bit(1'b1, 1'b1);
    end
    sda_m = 1'b1;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_m = 1'b0;
    tick(10);
    scl = 1'b0;
    s = {`SCT_I2C_ADDR, 1'b1, 8'hff};
    for (int i = 15; i >= 0; i--)
    begin
      i2c_bit(s[i], 1'b0);
      if (i == 8)
        i2c_bit(1'b1, 1'b1);
      if (i < 8)
        v = {v[6:0], rx_bit};
    end
    i2c_bit(1'b1, 1'b0);
    sda_m = 1'b0;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_m = 1'b1;
    tick(10);
  endtask
  task automatic wait_frame;
    k = 0;
    while (bc_frame !== 1'b1 && k < 3000)
    begin
      tick(1);
      k++;
    end
    check(k < 3000, 1'b1);
    tick(1);
  endtask
  // local master with a 16-cycle clock half period, ss held high for n + 2 frames after
  task automatic rev_xfer(input int n);
    ms_ss_n = 1'b0;
    wait_frame;
    wait_frame;
    check(bc_ss_n, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      ms_mosi = 1'($urandom);
      q.push_back(ms_mosi);
      tick(16);
      ms_sclk = 1'b1;
      tick(16);
      ms_sclk = 1'b0;
    end
    ms_ss_n = 1'b1;
    repeat (n + 2) wait_frame;
    check(16'(q.size()), 16'h0000);
    check(bc_ss_n, 1'b1);
  endtask
  always @(negedge clk)
  begin
    if (bc_frame === 1'b1)
      n_frames++;
    if ((rclk === 1'b1 && prev_clk === 1'b0 && rss_n === 1'b0) ||
        (rev && bc_frame === 1'b1 && bc_clk === 1'b1))
    begin
      check(q.size() > 0, 1'b1);
      if (q.size() > 0)
        check(rev ? bc_mosi : rmosi, q.pop_front());
    end
    // far-side miso seen at the last strobe reaches the local master
    if (rev && s_d === 1'b1)
      check(mmiso, m_d);
    s_d = strobe;
    m_d = f_miso;
    prev_clk = rclk;
  end
  initial
  begin
    k = $urandom(32'h8966);
    tick(10);
    resetn = 1'b1;
    tick(3);
    wr(`SCT_REG_MODE, {5'h00, `SCT_MODE_FWD});
    data = 8'($urandom);
    for (int i = 7; i >= 0; i--)
      q.push_back(data[i]);
    go = 1'b1;
    tick(8);
    go = 1'b0;
    k = 0;
    while (busy && k < 400)
    begin
      tick(1);
      k++;
    end
    check(k < 400, 1'b1);
    tick(20);
    check(16'(q.size()), 16'h0000);
    wait_frame;
    check(bc_miso, rmosi);
    lock = 1'b0;
    tick(2);
    check({rss_n, rclk}, 2'b10);
    lock = 1'b1;
    wr(`SCT_REG_MODE, {5'h00, `SCT_MODE_REV});
    rev = 1'b1;
    // far side toggles miso while the mode register is read back
    go = 1'b1;
    tick(8);
    go = 1'b0;
    rd(`SCT_REG_MODE, rv);
    check(rv, {5'h00, `SCT_MODE_REV});
    // fast-rate bit overrides the divider bit in the last entry
    foreach (rate[i])
    begin
      wr(`SCT_REG_BC, rate[i]);
      wait_frame;
      wait_frame;
      t0 = cyc;
      wait_frame;
      check(cyc - t0, per[i]);
    end
    rev_xfer(12);
    two = 1'b0;
    tick(2);
    k = n_frames;
    tick(2000);
    check(n_frames - k, 0);
    two = 1'b1;
    rev = 1'b0;
    wr(`SCT_REG_MODE, 8'h05);
    tick(10);
    k = n_frames;
    tick(2000);
    check(n_frames - k, 0);
    check(rss_n, 1'b1);
    report_and_stop;
  end
  initial
  begin
    tick(100000);
    n_fail++;
    report_and_stop;
  end
endmodule // sct_tunnel_test
`default_nettype wire
